// ==== bench/hffs_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ********
// Checker
// ********
module hffs_checker
  import hffs_pkg::*;
#(
  parameter int SETTLE_CYCLES = 20,
  parameter int FAULT_HOLD_CYCLES = 20
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire hffs_pkg::hffs_sense_t sense,
  input wire logic ref_select_a,
  input wire logic ref_select_b,
  input wire hffs_pkg::hffs_coil_t coil_drive,
  input wire hffs_pkg::hffs_ref_ctl_t reference_out,
  input wire logic sensed_output_valid,
  input wire logic over_range_flag_o,
  input wire logic over_range_flag_oe,
  input wire logic fault_flag_o,
  input wire logic fault_flag_oe
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  int low_reg;
  int hold_reg;
  int ovr_reg;
  logic both;
  assign both = ref_select_a & ref_select_b;
  // Run lengths are counted here since repetitions this long would stall the tools.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_reg <= 0;
      hold_reg <= 0;
      ovr_reg <= 0;
    end
    else
    begin
      low_reg <= sensed_output_valid ? 0 : low_reg + 1;
      hold_reg <= fault_flag_oe ? hold_reg + 1 : 0;
      ovr_reg <= sense.over_range ? ovr_reg + 1 : 0;
    end
  end
  property p_od; !over_range_flag_o && !fault_flag_o; endproperty
  a_od: assert property (p_od) else $error("flag driven high");
  property p_coil;
    !sensed_output_valid && !$past(sensed_output_valid) |-> coil_drive == 2'h0;
  endproperty
  a_coil: assert property (p_coil) else $error("coil driven early");
  property p_settle; $rose(sensed_output_valid) |-> low_reg >= SETTLE_CYCLES; endproperty
  a_settle: assert property (p_settle) else $error("settle too short");
  property p_hold; $fell(fault_flag_oe) |-> hold_reg >= FAULT_HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("fault hold too short");
  property p_filter; $rose(over_range_flag_oe) |-> ovr_reg >= OVR_FILTER_CYC; endproperty
  a_filter: assert property (p_filter) else $error("overload not filtered");
  property p_orf; over_range_flag_oe |-> ##[0:2] fault_flag_oe; endproperty
  a_orf: assert property (p_orf) else $error("no fault on overload");
  property p_hall;
    sense.hall_offset_high || sense.hall_disconnect |-> ##[1:6] fault_flag_oe;
  endproperty
  a_hall: assert property (p_hall) else $error("no fault on hall");
  property p_ref;
    $stable({ref_select_a, ref_select_b})[*6] |-> reference_out ==
      {(both ? HFFS_REF_RATIO : ref_select_a ? HFFS_REF_1V65 : HFFS_REF_2V5), !both, both};
  endproperty
  a_ref: assert property (p_ref) else $error("bad reference");
  c_or: cover property ($rose(over_range_flag_oe));
  c_run: cover property ($rose(sensed_output_valid));
  c_rel: cover property ($fell(fault_flag_oe));
endmodule
bind hffs_supervisor hffs_checker #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .FAULT_HOLD_CYCLES(FAULT_HOLD_CYCLES)
) u_hffs_checker (
  .ref_clk, .rst_n, .sense, .ref_select_a, .ref_select_b, .coil_drive,
  .reference_out, .sensed_output_valid, .over_range_flag_o, .over_range_flag_oe,
  .fault_flag_o, .fault_flag_oe
);
`default_nettype wire

// ==== bench/hffs_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ********
// Controller side of the flag lines
// ********
module hffs_ctrl_model
(
  input wire logic or_o,
  input wire logic or_oe,
  input wire logic flt_o,
  input wire logic flt_oe,
  output logic or_pin,
  output logic fault_pin
);
  // Only the board pull-up makes a released line read high.
  assign or_pin = or_oe ? or_o : 1'b1;
  assign fault_pin = flt_oe ? flt_o : 1'b1;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ********
// Bench
// ********
module tb_top;
  import hffs_pkg::*;
  localparam int SETC = 20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  hffs_sense_t sense = '0;
  logic ref_select_a = 1'b0;
  logic ref_select_b = 1'b0;
  hffs_coil_t coil_request = 2'h0;
  hffs_coil_t coil_drive;
  hffs_ref_ctl_t reference_out;
  logic valid, or_o, or_oe, flt_o, flt_oe, or_pin, fault_pin, avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  initial
    forever #10 ref_clk = ~ref_clk;
  hffs_supervisor #(.SETTLE_CYCLES(SETC), .FAULT_HOLD_CYCLES(SETC)) u_hffs_supervisor (
    .ref_clk, .rst_n, .sense, .ref_select_a, .ref_select_b, .coil_request, .coil_drive,
    .reference_out, .sensed_output_valid(valid), .over_range_flag_o(or_o),
    .over_range_flag_oe(or_oe), .fault_flag_o(flt_o), .fault_flag_oe(flt_oe),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest
  );
  hffs_ctrl_model u_hffs_ctrl_model (.or_o, .or_oe, .flt_o, .flt_oe, .or_pin, .fault_pin);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest)
      @(posedge ref_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_valid;
    for (int i = 0; i < 2000 && valid !== 1'b1; i++)
      @(posedge ref_clk);
  endtask
  task automatic close_out;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_start;
    tick(40);
    chk(valid, 1'b0);
    sense.supply_above_por <= 1'b1;
    coil_request <= 2'h3;
    tick(SETC);
    chk(coil_drive, 2'h0);
    chk(fault_pin, 1'b0);
    wait_valid();
    tick(2);
    chk(coil_drive, 2'h3);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[2:0], 3'h6);
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    tick(SETC + 8);
    chk(fault_pin, 1'b1);
  endtask
  task automatic t_ref;
    logic [1:0] sel [3] = '{2'h0, 2'h2, 2'h3};
    hffs_ref_t m [3] = '{HFFS_REF_2V5, HFFS_REF_1V65, HFFS_REF_RATIO};
    for (int i = 0; i < 3; i++)
    begin
      {ref_select_a, ref_select_b} <= sel[i];
      tick(8);
      chk(reference_out, {m[i], i < 2, i == 2});
    end
  endtask
  task automatic t_or;
    sense.over_range <= 1'b1;
    tick(100);
    sense.over_range <= 1'b0;
    tick(20);
    chk(or_pin, 1'b1);
    sense.over_range <= 1'b1;
    tick(OVR_FILTER_CYC + 12);
    chk(or_pin, 1'b0);
    chk(fault_pin, 1'b0);
    tick(100);
    chk(or_pin, 1'b0);
    sense.over_range <= 1'b0;
    tick(8);
    chk(or_pin, 1'b1);
    bus(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd[2:0], 3'h6);
    bus(1'b1, ADDR_EVENTS, 32'h2);
    bus(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd[2:0], 3'h4);
  endtask
  task automatic t_ctrl;
    bus(1'b1, ADDR_CTRL, 32'h2);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h2);
    tick(4);
    chk(coil_drive, 2'h0);
    chk(fault_pin, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h16);
    bus(1'b1, ADDR_CTRL, {30'h0, CTRL_RESET});
    tick(SETC + 8);
    chk(fault_pin, 1'b1);
    chk(coil_drive, 2'h3);
  endtask
  task automatic t_hall;
    for (int i = 0; i < 2; i++)
    begin
      tick(30);
      sense.hall_offset_high <= i == 0;
      sense.hall_disconnect <= i == 1;
      tick(8);
      chk(fault_pin, 1'b0);
      sense.hall_offset_high <= 1'b0;
      sense.hall_disconnect <= 1'b0;
      tick(10);
      chk(fault_pin, 1'b0);
      tick(25);
      chk(fault_pin, 1'b1);
    end
  endtask
  task automatic t_brown;
    sense.supply_brownout <= 1'b1;
    tick(BROWNOUT_CYC - 200);
    chk(valid, 1'b1);
    tick(220);
    chk(valid, 1'b0);
    chk(fault_pin, 1'b0);
    sense.supply_brownout <= 1'b0;
    tick(4);
    chk(coil_drive, 2'h0);
    wait_valid();
    chk(valid, 1'b1);
    bus(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd[2:0], 3'h5);
    bus(1'b1, ADDR_EVENTS, 32'h7);
    bus(1'b0, ADDR_EVENTS, 32'h0);
    chk(rd[2:0], 3'h0);
    sense.supply_below_min <= 1'b1;
    tick(2);
    sense.supply_below_min <= 1'b0;
    tick(6);
    chk(valid, 1'b0);
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      fails++;
      close_out();
    end
  end
  initial
  begin
    tick(16);
    rst_n <= 1'b1;
    t_start();
    t_ctrl();
    t_ref();
    t_or();
    t_hall();
    t_brown();
    close_out();
  end
endmodule
`default_nettype wire

// ==== logic/hffs_filter.sv ====
`timescale 1ns/100ps
`default_nettype none

module hffs_filter
  import hffs_pkg::*;
#(
  parameter int COUNT = 1
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level_out
);

  localparam int CW = $clog2(COUNT + 1);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [CW-1:0] cnt;
    logic level;
  } hffs_filter_st_t;

  hffs_filter_st_t st_reg;
  hffs_filter_st_t st_next;

  // ************************************************************
  // Synchroniser and persistence counter
  // ************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = async_in;
    st_next.sync2 = st_reg.sync1;
    // A low input releases at once; only the rising side is filtered.
    if (!st_reg.sync2)
    begin
      st_next.cnt = '0;
      st_next.level = 1'b0;
    end
    else if (st_reg.cnt == CW'(COUNT - 1))
    begin
      st_next.level = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;

endmodule

`default_nettype wire

// ==== logic/hffs_pkg.sv ====
package hffs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 50;
  localparam int OVR_FILTER_NS = 3000;
  localparam int SETTLE_NS = 100000;
  localparam int FAULT_HOLD_NS = 100000;
  localparam int BROWNOUT_NS = 25000;
  // Least times round up to whole cycles.
  localparam int OVR_FILTER_CYC = (OVR_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int FAULT_HOLD_CYC = (FAULT_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int BROWNOUT_CYC = (BROWNOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_ONLY_CYC = 1;
  localparam int CNT_W = 16;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVENTS = 4'h8;
  localparam int CTRL_COIL_EN_BIT = 0;
  localparam int CTRL_FORCE_FAULT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int EV_BROWNOUT_BIT = 0;
  localparam int EV_OVER_RANGE_BIT = 1;
  localparam int EV_FAULT_BIT = 2;
  localparam logic [2:0] EVENTS_RESET = 3'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    HFFS_SEQ_POR = 2'b00,
    HFFS_SEQ_SETTLE = 2'b01,
    HFFS_SEQ_RUN = 2'b10
  } hffs_seq_t;

  typedef enum logic [1:0] {
    HFFS_REF_2V5 = 2'b00,
    HFFS_REF_1V65 = 2'b01,
    HFFS_REF_RATIO = 2'b10
  } hffs_ref_t;

  // Analog comparator outputs, all asynchronous to ref_clk.
  typedef struct packed {
    logic supply_above_por;
    logic supply_below_min;
    logic supply_brownout;
    logic over_range;
    logic hall_offset_high;
    logic hall_disconnect;
  } hffs_sense_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } hffs_coil_t;

  typedef struct packed {
    hffs_ref_t mode;
    logic internal_en;
    logic divider_en;
  } hffs_ref_ctl_t;

endpackage

// ==== logic/hffs_supervisor.sv ====
//
// Contract
// - Overload comparator active pulls the over-range flag low.
// - Overload must persist 3 us before the over-range flag is raised.
// - Over-range flag releases when overload ends, stays while it lasts.
// - Select pins 00 give 2.5 V, 10 give 1.65 V, 11 give ratio-metric.
// - Ratio-metric mode bypasses the reference and routes half supply.
// - Logic starts when the supply rises above the 2.4 V threshold.
// - Wait 100 us of settling after reset release before normal operation.
// - Both coil driver outputs held low during settling.
// - Fault flag held low at least 100 us once an error arises.
// - Sensed output valid only 100 us after reset release.
// - Brownout lasting longer than 25 us enters power-on reset.
// - Supply below 1.8 V enters power-on reset at once.
// - After brownout reset the whole startup sequence runs again.
// - Active over-range flag also asserts the fault flag.
// - Fault flag on power failure, brownout or Hall out of range.
// - Fault flag when Hall offset exceeds 50 mV.
// - Fault flag when any Hall terminal is disconnected.
// - Both flags are open-drain: pulled low when active, else released.
// - All intervals timed by internal clock and counters only.
//
`timescale 1ns/100ps
`default_nettype none

module hffs_supervisor
  import hffs_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int FAULT_HOLD_CYCLES = FAULT_HOLD_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire hffs_pkg::hffs_sense_t sense,
  input wire logic ref_select_a,
  input wire logic ref_select_b,
  input wire hffs_pkg::hffs_coil_t coil_request,
  output hffs_pkg::hffs_coil_t coil_drive,
  output hffs_pkg::hffs_ref_ctl_t reference_out,
  output logic sensed_output_valid,
  output logic over_range_flag_o,
  output logic over_range_flag_oe,
  output logic fault_flag_o,
  output logic fault_flag_oe,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  typedef struct packed {
    hffs_seq_t seq;
    logic [CNT_W-1:0] settle_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic [1:0] ctrl;
    logic [2:0] events;
    logic ack;
    logic [31:0] rdata;
    hffs_coil_t coil;
    hffs_ref_ctl_t refc;
    logic valid;
    logic or_oe;
    logic fault_oe;
  } hffs_st_t;

  hffs_st_t st_reg;
  hffs_st_t st_next;

  logic above_por;
  logic below_min;
  logic offset_high;
  logic disconnect;
  logic brownout_long;
  logic over_range_filt;

  // ************************************************************
  // Comparator conditioning
  // ************************************************************
  // Offset and disconnect are only synchronised; the fault hold
  // stretches them, so no extra filtering is spent on them.
  hffs_filter #(.COUNT(SYNC_ONLY_CYC)) u_above_por
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sense.supply_above_por),
    .level_out(above_por)
  );

  hffs_filter #(.COUNT(SYNC_ONLY_CYC)) u_below_min
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sense.supply_below_min),
    .level_out(below_min)
  );

  hffs_filter #(.COUNT(SYNC_ONLY_CYC)) u_offset
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sense.hall_offset_high),
    .level_out(offset_high)
  );

  hffs_filter #(.COUNT(SYNC_ONLY_CYC)) u_disconnect
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sense.hall_disconnect),
    .level_out(disconnect)
  );

  hffs_filter #(.COUNT(BROWNOUT_CYC)) u_brownout
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sense.supply_brownout),
    .level_out(brownout_long)
  );

  hffs_filter #(.COUNT(OVR_FILTER_CYC)) u_over_range
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(sense.over_range),
    .level_out(over_range_filt)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic por_trigger;
  logic fault_cause;
  logic bus_req;
  logic bus_take;
  logic [31:0] status_word;

  always_comb
  begin
    st_next = st_reg;

    // A short dip only counts once it outlasts the brownout filter,
    // but losing the 1.8 V floor resets without waiting.
    por_trigger = brownout_long || below_min;

    case (st_reg.seq)
      HFFS_SEQ_POR:
      begin
        st_next.settle_cnt = '0;
        if (above_por && !por_trigger)
        begin
          st_next.seq = HFFS_SEQ_SETTLE;
        end
      end
      HFFS_SEQ_SETTLE:
      begin
        if (por_trigger || !above_por)
        begin
          st_next.seq = HFFS_SEQ_POR;
        end
        else if (st_reg.settle_cnt == CNT_W'(SETTLE_CYCLES - 1))
        begin
          st_next.seq = HFFS_SEQ_RUN;
        end
        else
        begin
          st_next.settle_cnt = st_reg.settle_cnt + CNT_W'(1);
        end
      end
      HFFS_SEQ_RUN:
      begin
        if (por_trigger || !above_por)
        begin
          st_next.seq = HFFS_SEQ_POR;
        end
      end
      default:
      begin
        st_next.seq = HFFS_SEQ_POR;
      end
    endcase

    // ************************************************************
    // Coil, reference and flag outputs
    // ************************************************************
    // Coil drive only passes in normal operation.
    if (st_reg.seq == HFFS_SEQ_RUN && st_reg.ctrl[CTRL_COIL_EN_BIT])
    begin
      st_next.coil = coil_request;
    end
    else
    begin
      st_next.coil = '0;
    end
    st_next.valid = (st_next.seq == HFFS_SEQ_RUN);

    // Pattern 01 is not a documented selection; it falls back to 2.5 V.
    if (ref_select_a && ref_select_b)
    begin
      st_next.refc.mode = HFFS_REF_RATIO;
      st_next.refc.internal_en = 1'b0;
      st_next.refc.divider_en = 1'b1;
    end
    else
    begin
      st_next.refc.mode = ref_select_a ? HFFS_REF_1V65 : HFFS_REF_2V5;
      st_next.refc.internal_en = 1'b1;
      st_next.refc.divider_en = 1'b0;
    end

    st_next.or_oe = over_range_filt;

    fault_cause = st_reg.or_oe
      || (st_reg.seq != HFFS_SEQ_RUN) || por_trigger
      || offset_high
      || disconnect
      || st_reg.ctrl[CTRL_FORCE_FAULT_BIT];
    if (fault_cause)
    begin
      st_next.hold_cnt = CNT_W'(FAULT_HOLD_CYCLES - 1);
      st_next.fault_oe = 1'b1;
    end
    else if (st_reg.hold_cnt != '0)
    begin
      st_next.hold_cnt = st_reg.hold_cnt - CNT_W'(1);
    end
    else
    begin
      st_next.fault_oe = 1'b0;
    end

    // ************************************************************
    // Register bus
    // ************************************************************
    // Avalon slave: every access is answered on the second edge.
    bus_req = avs_read || avs_write;
    bus_take = bus_req && st_reg.ack;
    st_next.ack = bus_req && !st_reg.ack;

    status_word = '0;
    status_word[1:0] = st_reg.seq;
    status_word[2] = st_reg.valid;
    status_word[3] = st_reg.or_oe;
    status_word[4] = st_reg.fault_oe;
    status_word[6:5] = st_reg.refc.mode;
    status_word[7] = offset_high;
    status_word[8] = disconnect;

    if (avs_read && !st_reg.ack)
    begin
      case (avs_address)
        ADDR_CTRL:
        begin
          st_next.rdata = {30'h0, st_reg.ctrl};
        end
        ADDR_STATUS:
        begin
          st_next.rdata = status_word;
        end
        ADDR_EVENTS:
        begin
          st_next.rdata = {29'h0, st_reg.events};
        end
        default:
        begin
          st_next.rdata = 32'h0;
        end
      endcase
    end

    if (bus_take && avs_write && avs_byteenable[0])
    begin
      if (avs_address == ADDR_CTRL)
      begin
        st_next.ctrl = avs_writedata[1:0];
      end
      else if (avs_address == ADDR_EVENTS)
      begin
        st_next.events = st_reg.events & ~avs_writedata[2:0];
      end
    end

    // ************************************************************
    // Event capture
    // ************************************************************
    // Hardware set is applied after the clear so a same-cycle event wins.
    // Leaving normal operation is judged on the next state, because valid
    // mirrors the state register and never differs from it.
    if (st_next.seq != HFFS_SEQ_RUN && st_reg.valid)
    begin
      st_next.events[EV_BROWNOUT_BIT] = 1'b1;
    end
    if (over_range_filt && !st_reg.or_oe)
    begin
      st_next.events[EV_OVER_RANGE_BIT] = 1'b1;
    end
    if (st_next.fault_oe && !st_reg.fault_oe)
    begin
      st_next.events[EV_FAULT_BIT] = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.seq <= HFFS_SEQ_POR;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.events <= EVENTS_RESET;
      st_reg.refc.internal_en <= 1'b1;
      st_reg.fault_oe <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign coil_drive = st_reg.coil;
  assign reference_out = st_reg.refc;
  assign sensed_output_valid = st_reg.valid;
  assign over_range_flag_o = 1'b0;
  assign over_range_flag_oe = st_reg.or_oe;
  assign fault_flag_o = 1'b0;
  assign fault_flag_oe = st_reg.fault_oe;
  assign avs_readdata = st_reg.rdata;
  // Every request is held off for exactly one cycle, so read data can
  // always come straight from a register.
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;

endmodule

`default_nettype wire
